/* inc/capture_pkg.sv */
package capture_pkg;

	// ---------------------------------------------------------------
	// Sizes and field positions
	// ---------------------------------------------------------------
	localparam int          SRC_COUNT   = 24;
	localparam int          SET_W       = 24;
	localparam int          ADDR_W      = 16;
	localparam int          WORD_W      = 24;
	localparam int          MOTOR_W     = 4;
	localparam int          LONG_BIT    = 23;   // Both X and Y as long
	localparam int          XSEL_BIT    = 22;   // X only when not long
	localparam logic [4:0]  SRC_LAST    = 5'h17;

	// ---------------------------------------------------------------
	// Buffer placement and host-visible offsets
	// ---------------------------------------------------------------
	localparam logic [15:0] DPRAM_BASE      = 16'hD240;
	localparam logic [15:0] HOST_BUF_OFS    = 16'h0900;
	localparam logic [15:0] HOST_STATUS_OFS = 16'h08FC;
	localparam logic [15:0] RAM_BASE        = 16'h4000;
	localparam logic [1:0]  MODE_RAM_STOP   = 2'h0;
	localparam logic [1:0]  MODE_RAM_WRAP   = 2'h1;
	localparam logic [1:0]  MODE_DPR_STOP   = 2'h2;
	localparam logic [1:0]  MODE_DPR_WRAP   = 2'h3;
	localparam int          MODE_WRAP_BIT   = 0;
	localparam int          MODE_DPR_BIT    = 1;

	// ---------------------------------------------------------------
	// Reset values and steps
	// ---------------------------------------------------------------
	localparam logic [23:0] SET_RESET   = 24'h000000;
	localparam logic [23:0] STEP_SHORT  = 24'h000001;
	localparam logic [23:0] STEP_LONG   = 24'h000002;
	localparam logic [23:0] CNT_ONE     = 24'h000001;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_WAIT = 6'h02,
		S_SCAN = 6'h04,
		S_DATA = 6'h08,
		S_HALT = 6'h10,
		S_SPARE = 6'h20
	} cap_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0]   addr;
		logic                long_word;
		logic [2*WORD_W-1:0] data;   // {X, Y}; short word in Y half
	} entry_t;

	typedef struct packed {
		cap_state_t                    st;
		logic [SRC_COUNT-1:0][SET_W-1:0] src;
		logic [23:0]                   size;
		logic [23:0]                   idx;
		logic [1:0]                    mode;
		logic                          running;
		logic [23:0]                   tick_cnt;
		logic [4:0]                    sel;
		logic [4:0]                    pick;
		logic                          mem_rd;
		logic [ADDR_W-1:0]             mem_addr;
		logic [1:0]                    mem_space;
		logic                          servo_copy;
		logic [MOTOR_W-1:0]            servo_motors;
		logic                          halted;
		logic                          v0;
		logic                          v1;
		entry_t                        e0;
		entry_t                        e1;
	} cap_reg_t;

endpackage

/* core/capture_engine.sv */
`timescale 1ns/1ps

// Operation
// - A 24-bit source mask enables source n+1 with bit n, bit 0 first.
// - Twenty-four source settings of 24 bits share one format.
// - The low 16 bits of a setting are the word address to sample.
// - With both top bits zero only the Y word is captured.
// - With top bit zero and next bit one only the X word is captured.
// - With the top bit set X and Y form one long word, next bit ignored.
// - Mode 0/1 place the buffer in RAM, 2/3 in dual-port RAM; odd wraps.
// - Dual-port buffers start at D240, host offset 0900, define sets size.
// - The buffer size is published in the Y half at host offset 08FC.
// - The index sits in the X half of 08FC; non-wrap halts at size.
// - Servo reporting copies servo data once per period while running.
// - With servo reporting off no copy happens and capture still works.
// - One sample every N servo ticks; N of zero samples once per start.
module capture_engine
	import capture_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                servo_tick,
	input  wire logic [23:0]         capture_period,
	input  wire logic [23:0]         capture_source_mask,
	input  wire logic [1:0]          capture_buffer_mode,
	input  wire logic                servo_report_enable,
	input  wire logic [MOTOR_W-1:0]  reported_motor_count,
	input  wire logic                src_wr,
	input  wire logic [4:0]          src_idx,
	input  wire logic [SET_W-1:0]    src_data,
	input  wire logic                cmd_define,
	input  wire logic [23:0]         define_length,
	input  wire logic                cmd_start,
	input  wire logic                cmd_stop,
	output      logic                mem_rd_q,
	output      logic [ADDR_W-1:0]   mem_addr_q,
	output      logic [1:0]          mem_space_q,
	input  wire logic                mem_rd_valid,
	input  wire logic [2*WORD_W-1:0] mem_rd_data,
	output      logic                wr_valid_q,
	input  wire logic                wr_ready,
	output      logic [ADDR_W-1:0]   wr_addr_q,
	output      logic                wr_long_q,
	output      logic [2*WORD_W-1:0] wr_data_q,
	output      logic [23:0]         buffer_size_q,
	output      logic [23:0]         store_index_q,
	output      logic                halted_q,
	output      logic                servo_copy_q,
	output      logic [MOTOR_W-1:0]  servo_motors_q
);

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	cap_reg_t r_q;
	cap_reg_t r_d;
	logic     push_c;
	logic     trig_c;
	logic     hit_c;
	logic [4:0] pick_c;
	entry_t   new_c;

	// Outputs straight from the state flops
	assign mem_rd_q       = r_q.mem_rd;
	assign mem_addr_q     = r_q.mem_addr;
	assign mem_space_q    = r_q.mem_space;
	assign wr_valid_q     = r_q.v0;
	assign wr_addr_q      = r_q.e0.addr;
	assign wr_long_q      = r_q.e0.long_word;
	assign wr_data_q      = r_q.e0.data;
	assign buffer_size_q  = r_q.size;
	assign store_index_q  = r_q.idx;
	assign halted_q       = r_q.halted;
	assign servo_copy_q   = r_q.servo_copy;
	assign servo_motors_q = r_q.servo_motors;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic [23:0] step;
		logic        is_long;
		logic [15:0] base;
		r_d        = r_q;
		push_c     = 1'b0;
		trig_c     = 1'b0;
		hit_c      = 1'b0;
		pick_c     = 5'h00;
		new_c      = '0;
		step       = STEP_SHORT;
		is_long    = 1'b0;
		base       = RAM_BASE;
		r_d.mem_rd = 1'b0;
		r_d.servo_copy = 1'b0;

		// Setting writes, one source at a time
		if (src_wr && src_idx <= SRC_LAST) begin
			r_d.src[src_idx] = src_data;
		end

		// Drain side of the two-entry buffer
		if (wr_ready && r_q.v0) begin
			r_d.e0 = r_q.e1;
			r_d.v0 = r_q.v1;
			r_d.v1 = 1'b0;
		end

		// Lowest enabled source at or above the scan position
		for (int i = 0; i < SRC_COUNT; i++) begin
			if (!hit_c && i >= int'(r_q.sel) &&
			    capture_source_mask[i]) begin
				hit_c  = 1'b1;
				pick_c = 5'(i);
			end
		end

		// Sample trigger from start or from the period count
		if (cmd_start && (r_q.st == S_IDLE || r_q.st == S_WAIT)) begin
			r_d.running  = 1'b1;
			r_d.tick_cnt = SET_RESET;
			trig_c       = 1'b1;
		end else if (r_q.st == S_WAIT && r_q.running && servo_tick &&
		             capture_period != SET_RESET) begin
			if (r_q.tick_cnt + CNT_ONE >= capture_period) begin
				r_d.tick_cnt = SET_RESET;
				trig_c       = 1'b1;
			end else begin
				r_d.tick_cnt = r_q.tick_cnt + CNT_ONE;
			end
		end

		// Servo report once per period
		if (trig_c && servo_report_enable) begin
			r_d.servo_copy   = 1'b1;
			r_d.servo_motors = reported_motor_count;
		end

		case (r_q.st)
			S_IDLE: begin
				if (trig_c) begin
					r_d.st  = S_SCAN;
					r_d.sel = 5'h00;
				end
			end
			S_WAIT: begin
				if (!r_q.running || cmd_stop) begin
					r_d.running = 1'b0;
					r_d.st      = S_IDLE;
				end else if (trig_c) begin
					r_d.st  = S_SCAN;
					r_d.sel = 5'h00;
				end
			end
			S_SCAN: begin
				if (!hit_c) begin
					r_d.st = S_WAIT;                      // Sample done
				end else if (r_q.idx >= r_q.size &&
				             !r_q.mode[MODE_WRAP_BIT]) begin
					r_d.st     = S_HALT;
					r_d.halted = 1'b1;
				end else if (!r_q.v1) begin
					if (r_q.idx >= r_q.size) begin
						r_d.idx = SET_RESET;
					end
					r_d.pick      = pick_c;
					r_d.mem_rd    = 1'b1;
					r_d.mem_addr  = r_q.src[pick_c][ADDR_W-1:0];
					r_d.mem_space = r_q.src[pick_c][LONG_BIT:XSEL_BIT];
					r_d.st        = S_DATA;
				end
			end
			S_DATA: begin
				if (mem_rd_valid) begin
					is_long = r_q.mem_space[1];
					base    = r_q.mode[MODE_DPR_BIT] ? DPRAM_BASE
					                                  : RAM_BASE;
					new_c.addr      = base + r_q.idx[15:0];
					new_c.long_word = is_long;
					if (is_long) begin
						new_c.data = mem_rd_data;
					end else if (r_q.mem_space[0]) begin
						new_c.data = {{WORD_W{1'b0}},
						              mem_rd_data[2*WORD_W-1:WORD_W]};
					end else begin
						new_c.data = {{WORD_W{1'b0}},
						              mem_rd_data[WORD_W-1:0]};
					end
					step    = is_long ? STEP_LONG : STEP_SHORT;
					r_d.idx = r_q.idx + step;
					push_c  = 1'b1;
					r_d.sel = r_q.pick + 5'h01;
					r_d.st  = S_SCAN;
				end
			end
			S_HALT: begin
				r_d.halted = 1'b1;
			end
			default: begin
				r_d.st = S_IDLE;
			end
		endcase

		// Fill side of the two-entry buffer, after the drain
		if (push_c) begin
			if (!r_d.v0) begin
				r_d.e0 = new_c;
				r_d.v0 = 1'b1;
			end else begin
				r_d.e1 = new_c;
				r_d.v1 = 1'b1;
			end
		end

		// Stop request while a sample is in flight
		if (cmd_stop) begin
			r_d.running = 1'b0;
		end

		// Define resets the buffer and aborts capture
		if (cmd_define) begin
			r_d.size    = define_length;
			r_d.idx     = SET_RESET;
			r_d.mode    = capture_buffer_mode;
			r_d.running = 1'b0;
			r_d.halted  = 1'b0;
			r_d.st      = S_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// Register stage
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_q    <= '0;
			r_q.st <= S_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_MASK_BIT:
	assert property (@(posedge clk) disable iff (reset)
		mem_rd_q |-> capture_source_mask[r_q.pick])
	else $error("read issued for a disabled source");

	AST_ADDR_LOW:
	assert property (@(posedge clk) disable iff (reset)
		mem_rd_q |-> mem_addr_q == r_q.src[r_q.pick][ADDR_W-1:0])
	else $error("read address differs from setting");

	AST_Y_ONLY:
	assert property (@(posedge clk) disable iff (reset)
		(push_c && r_q.mem_space == 2'h0) |=>
		(r_q.v1 ? r_q.e1.data : r_q.e0.data) ==
		{{WORD_W{1'b0}}, $past(mem_rd_data[WORD_W-1:0])})
	else $error("Y word not stored alone");

	AST_X_ONLY:
	assert property (@(posedge clk) disable iff (reset)
		(push_c && r_q.mem_space == 2'h1) |=>
		(r_q.v1 ? r_q.e1.data : r_q.e0.data) ==
		{{WORD_W{1'b0}}, $past(mem_rd_data[2*WORD_W-1:WORD_W])})
	else $error("X word not stored alone");

	AST_LONG_STEP:
	assert property (@(posedge clk) disable iff (reset)
		(push_c && r_q.mem_space[1] && !cmd_define) |=>
		store_index_q == $past(store_index_q) + STEP_LONG)
	else $error("long word did not advance index by two");

	AST_SHORT_STEP:
	assert property (@(posedge clk) disable iff (reset)
		(push_c && !r_q.mem_space[1] && !cmd_define) |=>
		store_index_q == $past(store_index_q) + STEP_SHORT)
	else $error("short word did not advance index by one");

	AST_DPR_BASE:
	assert property (@(posedge clk) disable iff (reset)
		(push_c && r_q.mode[MODE_DPR_BIT]) |->
		new_c.addr == DPRAM_BASE + store_index_q[15:0])
	else $error("dual-port entry not at its base");

	AST_SIZE_HOLD:
	assert property (@(posedge clk) disable iff (reset)
		!cmd_define |=> $stable(buffer_size_q))
	else $error("buffer size changed without define");

	AST_HALT_STOP:
	assert property (@(posedge clk) disable iff (reset)
		(r_q.st == S_SCAN && hit_c && !r_q.mode[MODE_WRAP_BIT] &&
		 store_index_q >= buffer_size_q && !cmd_define) |=>
		halted_q ##1 (halted_q || $past(cmd_define)))
	else $error("non-wrap buffer did not halt at its size");

	AST_SERVO_COPY:
	assert property (@(posedge clk) disable iff (reset)
		(trig_c && servo_report_enable) |=>
		servo_copy_q && servo_motors_q == $past(reported_motor_count))
	else $error("servo report missed a period");

	AST_SERVO_OFF:
	assert property (@(posedge clk) disable iff (reset)
		!servo_report_enable |=> !servo_copy_q)
	else $error("servo copy while reporting disabled");

	AST_ONE_SHOT:
	assert property (@(posedge clk) disable iff (reset)
		(r_q.st == S_WAIT && capture_period == SET_RESET &&
		 !cmd_start) |-> !trig_c)
	else $error("period zero retriggered without start");

	AST_NO_OVERFILL:
	assert property (@(posedge clk) disable iff (reset)
		(r_q.v0 && r_q.v1 && !wr_ready) |-> !push_c)
	else $error("buffer written while full");

	AST_MODE_HOLD:
	assert property (@(posedge clk) disable iff (reset)
		cmd_define |=> r_q.mode == $past(capture_buffer_mode))
	else $error("buffer mode not taken at define");

	AST_WRAP_ZERO:
	assert property (@(posedge clk) disable iff (reset)
		(r_q.st == S_SCAN && hit_c && r_q.mode[MODE_WRAP_BIT] &&
		 !r_q.v1 && store_index_q >= buffer_size_q && !cmd_define) |=>
		store_index_q == SET_RESET)
	else $error("wrapping buffer did not restart at zero");

	AST_START_SCAN:
	assert property (@(posedge clk) disable iff (reset)
		(cmd_start && r_q.st == S_IDLE && !cmd_define) |=> r_q.st == S_SCAN)
	else $error("start did not begin a sample");

	AST_HALT_NO_READ:
	assert property (@(posedge clk) disable iff (reset)
		halted_q |-> !mem_rd_q)
	else $error("read issued while halted");

endmodule

/* test/capture_far_side.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Memory that answers reads, and a receiver that takes words
// ------------------------------------------------------------
module capture_far_side
	import capture_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                slow,
	input  wire logic                mem_rd_q,
	input  wire logic [ADDR_W-1:0]   mem_addr_q,
	output      logic                mem_rd_valid,
	output      logic [2*WORD_W-1:0] mem_rd_data,
	output      logic                wr_ready
);
	logic [3:0] wait_q;
	logic       busy_q;

	// Idle outputs at time zero
	initial begin
		{mem_rd_valid, busy_q, wait_q, wr_ready} = '0;
		mem_rd_data = 48'h5A5A5A5A5A5A;
	end

	// Answer after one or five cycles, junk on the bus otherwise
	always @(posedge clk) begin
		mem_rd_valid <= 1'b0;
		mem_rd_data  <= ~mem_rd_data;
		wr_ready     <= slow ? ~wr_ready : 1'b1; // Stalls when slow
		if (mem_rd_q) begin
			busy_q <= 1'b1;
			wait_q <= slow ? 4'h4 : 4'h0;
		end else if (busy_q && wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (busy_q) begin
			busy_q       <= 1'b0;
			mem_rd_valid <= 1'b1;
			mem_rd_data  <= {8'hA1, mem_addr_q, 8'hB2, mem_addr_q};
		end
	end
endmodule

/* test/tb.sv */
`timescale 1ns/1ps

module tb
	import capture_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                clk, reset, servo_tick, src_wr, slow;
	logic                servo_report_enable, cmd_define, cmd_start;
	logic                cmd_stop, mem_rd_q, mem_rd_valid, wr_ready;
	logic                wr_valid_q, wr_long_q, halted_q, servo_copy_q;
	logic [23:0]         capture_period, capture_source_mask;
	logic [23:0]         define_length, src_data;
	logic [23:0]         buffer_size_q, store_index_q;
	logic [1:0]          capture_buffer_mode, mem_space_q;
	logic [4:0]          src_idx;
	logic [MOTOR_W-1:0]  reported_motor_count, servo_motors_q, motors;
	logic [ADDR_W-1:0]   mem_addr_q, wr_addr_q;
	logic [2*WORD_W-1:0] mem_rd_data, wr_data_q;
	logic [64:0]         q[$];
	int                  n_fail, comparisons, n_copy;

	capture_engine dut (.clk, .reset, .servo_tick, .capture_period,
		.capture_source_mask, .capture_buffer_mode, .servo_report_enable,
		.reported_motor_count, .src_wr, .src_idx, .src_data, .cmd_define,
		.define_length, .cmd_start, .cmd_stop, .mem_rd_q, .mem_addr_q,
		.mem_space_q, .mem_rd_valid, .mem_rd_data, .wr_valid_q, .wr_ready,
		.wr_addr_q, .wr_long_q, .wr_data_q, .buffer_size_q, .store_index_q,
		.halted_q, .servo_copy_q, .servo_motors_q);
	capture_far_side far (.clk, .slow, .mem_rd_q, .mem_addr_q,
		.mem_rd_valid, .mem_rd_data, .wr_ready);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// Collect popped entries and servo copy pulses
	always @(posedge clk) begin
		if (wr_valid_q === 1'b1 && wr_ready === 1'b1)
			q.push_back({wr_addr_q, wr_long_q, wr_data_q});
		if (servo_copy_q === 1'b1) begin
			n_copy++;
			motors = servo_motors_q;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic set_src(input logic [4:0] i, input logic [23:0] d);
		@(negedge clk);
		{src_wr, src_idx, src_data} = {1'b1, i, d};
		@(negedge clk);
		src_wr = 1'b0;
	endtask

	task automatic define(input logic [1:0] m, input logic [23:0] len);
		@(negedge clk);
		{cmd_define, capture_buffer_mode, define_length} = {1'b1, m, len};
		@(negedge clk);
		cmd_define = 1'b0;
	endtask

	task automatic start();
		@(negedge clk);
		cmd_start = 1'b1;
		@(negedge clk);
		cmd_start = 1'b0;
	endtask

	task automatic ticks(input int n, input int gap);
		repeat (n) begin
			@(negedge clk);
			servo_tick = 1'b1;
			@(negedge clk);
			servo_tick = 1'b0;
			repeat (gap) @(negedge clk);
		end
	endtask

	task automatic wait_pops(input int n);
		for (int i = 0; i < 3000 && q.size() < n; i++)
			@(negedge clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Four sources of all widths, mask bits 0, 1, 2 and 23
	task automatic t_order();
		set_src(5'h00, 24'h000720);
		set_src(5'h01, 24'h400721);
		set_src(5'h02, 24'hC00722);
		set_src(5'h17, 24'h800723);
		capture_source_mask = 24'h800007;
		define(MODE_DPR_WRAP, 24'h000064);
		start();
		wait_pops(4);
		ticks(3, 20);
		chk(q.size(), 4);
		chk(q[0], {16'hD240, 1'b0, 24'h0, 24'hB20720});
		chk(q[1], {16'hD241, 1'b0, 24'h0, 24'hA10721});
		chk(q[2], {16'hD242, 1'b1, 48'hA10722B20722});
		chk(q[3], {16'hD244, 1'b1, 48'hA10723B20723});
		chk(store_index_q, 24'h000006);
		chk(buffer_size_q, 24'h000064);
		chk(mem_space_q, 2'h2);
	endtask

	// Non-wrapping dual-port buffer fills and halts
	task automatic t_stop();
		q.delete();
		capture_source_mask = 24'h000001;
		capture_period = 24'h000001;
		define(MODE_DPR_STOP, 24'h000003);
		start();
		wait_pops(1);
		n_copy = 0;
		ticks(4, 20);
		chk(q.size(), 3);
		chk({halted_q, store_index_q}, {1'b1, 24'h000003});
		chk(n_copy, 0);
		define(MODE_DPR_STOP, 24'h000003);
		chk({halted_q, store_index_q}, 25'h0);
	endtask

	// Wrapping regular buffer, period two, stalling receiver
	task automatic t_wrap();
		q.delete();
		{slow, servo_report_enable, reported_motor_count} = {2'b11, 4'h5};
		capture_period = 24'h000002;
		define(MODE_RAM_WRAP, 24'h000002);
		start();
		wait_pops(1);
		n_copy = 0;
		ticks(6, 40);
		chk(q.size(), 4);
		chk(q[2][64:49], RAM_BASE);
		chk(q[3][64:49], RAM_BASE + 16'h0001);
		chk(halted_q, 1'b0);
		chk({n_copy[3:0], motors}, {4'h3, 4'h5});
		@(negedge clk);
		cmd_stop = 1'b1;
		@(negedge clk);
		cmd_stop = 1'b0;
		ticks(2, 40);
		chk(q.size(), 4);
		slow = 1'b0;
	endtask

	// Stopping regular buffer, start refused when halted, then reset
	task automatic t_ram_stop();
		q.delete();
		define(MODE_RAM_STOP, 24'h000001);
		start();
		wait_pops(1);
		ticks(2, 20);
		chk(q.size(), 1);
		chk(q[0], {RAM_BASE, 1'b0, 24'h0, 24'hB20720});
		chk({halted_q, store_index_q}, {1'b1, 24'h000001});
		start();
		ticks(1, 20);
		chk(q.size(), 1);
		@(negedge clk);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		chk({halted_q, wr_valid_q, store_index_q}, 26'h0);
		chk(buffer_size_q, 24'h0);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{clk, servo_tick, src_wr, slow, servo_report_enable} = '0;
		{cmd_define, cmd_start, cmd_stop, src_idx, src_data} = '0;
		{capture_period, capture_source_mask, define_length} = '0;
		{capture_buffer_mode, reported_motor_count, n_copy} = '0;
		{n_fail, comparisons} = '0;
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		chk({halted_q, wr_valid_q, store_index_q}, 26'h0);
		chk(buffer_size_q, 24'h0);
		t_order();
		t_stop();
		t_wrap();
		t_ram_stop();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
endmodule
